/* verilog/fpec_top.sv */
// Flash protect, emulation entry and erase/write guard with AHB-Lite registers
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
module fpec_top
  import fpec_pkg::*;
#(
  parameter int BLOCKS    = FPEC_BLOCKS,
  parameter int PE_CYCLES = FPEC_PE_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        protect_pin,
  input  wire logic        boot_mode,
  input  wire logic        programmer_clock_in,
  input  wire logic        programmer_data_in,
  output logic             programmer_data_out,
  output logic             transfer_enable_out,
  output logic             emulation_active,
  output logic             ram_window_hit,
  output logic             irq
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic       sclk_last;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta  <= 2'b11;
      pin_sync  <= 2'b11;
      sclk_last <= 1'b1;
    end else if (ce) begin
      pin_meta  <= {programmer_clock_in, protect_pin};
      pin_sync  <= pin_meta;
      sclk_last <= pin_sync[1];
    end
  end
  logic [1:0] data_meta;
  logic [1:0] data_sync;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_meta <= 2'b01;
      data_sync <= 2'b01;
    end else if (ce) begin
      data_meta <= {boot_mode, programmer_data_in};
      data_sync <= data_meta;
    end
  end
  logic pin_high;
  logic sclk_rise;
  logic sclk_fall;
  assign pin_high  = pin_sync[0];
  assign sclk_rise = pin_sync[1] & ~sclk_last;
  assign sclk_fall = ~pin_sync[1] & sclk_last;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic in_ram(input logic [31:0] a);
    in_ram = (a >= FPEC_RAM_LOW) && (a <= FPEC_RAM_HIGH);
  endfunction

  // ---------------------------------------------------------------
  // AHB-Lite address phase capture
  // ---------------------------------------------------------------
  logic       wr_pend;
  logic [7:0] acc_off;
  logic       take;
  assign take = hsel & hready & htrans[1];

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {FPEC_IDLE, FPEC_BUSY, FPEC_DONE} fpec_state_t;
  fpec_state_t state;
  fpec_state_t next_state;
  logic [31:0] ctr;
  logic [31:0] next_ctr;
  logic        arm;
  logic        next_arm;
  logic        arm_zero_seen;
  logic        next_arm_zero_seen;
  logic        emu_sel;
  logic        next_emu_sel;
  logic        emu_en;
  logic        next_emu_en;
  logic [BLOCKS-1:0] lock;
  logic [BLOCKS-1:0] next_lock;
  logic [7:0]  stat_two;
  logic [7:0]  next_stat_two;
  logic [FPEC_IRQ_WIDTH-1:0] irq_stat;
  logic [FPEC_IRQ_WIDTH-1:0] next_irq_stat;
  logic [FPEC_IRQ_WIDTH-1:0] irq_mask;
  logic [FPEC_IRQ_WIDTH-1:0] next_irq_mask;
  logic [7:0]  tx_word;
  logic [7:0]  next_tx_word;
  logic [31:0] ram_probe;
  logic [31:0] next_ram_probe;
  logic [31:0] next_hrdata;
  logic        next_irq;
  logic        next_emu_active;
  logic        next_ram_hit;
  logic        next_txen;
  logic [7:0]  rx_word;
  logic        rx_done;

  logic        wr_now;
  logic        cmd_go;
  logic [4:0]  cmd_blk;
  logic        cmd_ok;
  assign wr_now  = wr_pend;
  assign cmd_blk = hwdata[FPEC_CMD_BLOCK_LSB +: 5];
  assign cmd_go  = wr_now && acc_off == FPEC_OFF_COMMAND &&
                   (hwdata[FPEC_BIT_CMD_ERASE] | hwdata[FPEC_BIT_CMD_WRITE]);
  // Erase/write only when armed, pin high and block unlocked
  assign cmd_ok  = arm && pin_high && lock[cmd_blk] && state == FPEC_IDLE;

  always_comb begin
    next_state         = state;
    next_ctr           = ctr;
    next_arm           = arm;
    next_arm_zero_seen = arm_zero_seen;
    next_emu_sel       = emu_sel;
    next_emu_en        = emu_en;
    next_lock          = lock;
    next_stat_two      = stat_two;
    next_irq_stat      = irq_stat;
    next_irq_mask      = irq_mask;
    next_tx_word       = tx_word;
    next_ram_probe     = ram_probe;
    // Sequencer
    case (state)
      FPEC_IDLE: begin
        if (cmd_go && cmd_ok) begin
          next_state = FPEC_BUSY;
          next_ctr   = 32'(PE_CYCLES - 1);
        end
      end
      FPEC_BUSY: begin
        if (ctr == 32'h0) begin
          next_state = FPEC_DONE;
        end else begin
          next_ctr = ctr - 32'h1;
        end
      end
      FPEC_DONE: begin
        next_state = FPEC_IDLE;
      end
      default: next_state = FPEC_IDLE;
    endcase
    // Register writes
    if (wr_now) begin
      case (acc_off)
        FPEC_OFF_CONTROL_ONE: begin
          next_emu_sel = hwdata[FPEC_BIT_EMU_SELECT];
          if (!hwdata[FPEC_BIT_EMU_SELECT]) begin
            next_emu_en = 1'b0;
          end
          if (!hwdata[FPEC_BIT_ENTRY_ARM]) begin
            // A zero write clears the arm and opens the sequence
            next_arm           = 1'b0;
            next_arm_zero_seen = 1'b1;
          end else begin
            if (arm_zero_seen && pin_high) begin
              next_arm = 1'b1;
            end
            next_arm_zero_seen = 1'b0;
          end
        end
        FPEC_OFF_CONTROL_FOUR: begin
          if (hwdata[FPEC_BIT_FLASH_RESET]) begin
            next_stat_two = FPEC_STATUS_TWO_RESET;
          end
        end
        FPEC_OFF_BANK_MAP: begin
          // Substitution enables only once emulation mode is in
          next_emu_en = hwdata[FPEC_BIT_EMU_ENABLE] & emu_sel;
        end
        FPEC_OFF_LOCK:      next_lock      = hwdata[BLOCKS-1:0];
        FPEC_OFF_IRQ_MASK:  next_irq_mask  = hwdata[FPEC_IRQ_WIDTH-1:0];
        FPEC_OFF_IRQ_STATUS: next_irq_stat = irq_stat & ~hwdata[FPEC_IRQ_WIDTH-1:0];
        FPEC_OFF_LINK_DATA: next_tx_word   = hwdata[7:0];
        FPEC_OFF_RAM_CHECK: next_ram_probe = hwdata;
        default: ;
      endcase
    end
    // Any other register write breaks the 0-then-1 sequence
    if (wr_now && acc_off != FPEC_OFF_CONTROL_ONE) begin
      next_arm_zero_seen = 1'b0;
    end
    if (!pin_high) begin
      next_arm_zero_seen = 1'b0;
    end
    // Command rejected for pin low or a locked block records an error
    if (cmd_go && !cmd_ok) begin
      if (!pin_high) begin
        next_stat_two[FPEC_BIT_ERR_PROTECT] = 1'b1;
      end else if (!lock[cmd_blk]) begin
        next_stat_two[FPEC_BIT_ERR_LOCK] = 1'b1;
      end
    end
    next_stat_two[FPEC_BIT_PE_IDLE] = (next_state != FPEC_BUSY);
    // Events set after clears so a same-cycle set wins
    if (state == FPEC_DONE) next_irq_stat[FPEC_IRQ_DONE] = 1'b1;
    if (cmd_go && !cmd_ok) next_irq_stat[FPEC_IRQ_REJECT] = 1'b1;
    if (rx_done) next_irq_stat[FPEC_IRQ_LINK_BYTE] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state         <= FPEC_IDLE;
      ctr           <= 32'h0;
      arm           <= 1'b0;
      arm_zero_seen <= 1'b0;
      emu_sel       <= 1'b0;
      emu_en        <= 1'b0;
      lock          <= BLOCKS'(FPEC_LOCK_RESET);
      stat_two      <= FPEC_STATUS_TWO_RESET;
      irq_stat      <= '0;
      irq_mask      <= '0;
      tx_word       <= 8'hff;
      ram_probe     <= 32'h0;
    end else if (ce) begin
      state         <= next_state;
      ctr           <= next_ctr;
      arm           <= next_arm;
      arm_zero_seen <= next_arm_zero_seen;
      emu_sel       <= next_emu_sel;
      emu_en        <= next_emu_en;
      lock          <= next_lock;
      stat_two      <= next_stat_two;
      irq_stat      <= next_irq_stat;
      irq_mask      <= next_irq_mask;
      tx_word       <= next_tx_word;
      ram_probe     <= next_ram_probe;
    end
  end

  // ---------------------------------------------------------------
  // Read mux and outputs
  // ---------------------------------------------------------------
  always_comb begin
    next_hrdata = hrdata;
    if (take && !hwrite) begin
      case (haddr[7:0])
        FPEC_OFF_CONTROL_ONE:
          next_hrdata = 32'({emu_sel, arm});
        FPEC_OFF_STATUS_ONE:
          next_hrdata = 32'({(state != FPEC_BUSY), 7'h00});
        FPEC_OFF_STATUS_TWO: next_hrdata = 32'(stat_two);
        FPEC_OFF_MODE:
          next_hrdata = 32'({data_sync[1], pin_high});
        FPEC_OFF_BANK_MAP:   next_hrdata = 32'(emu_en);
        FPEC_OFF_LOCK:       next_hrdata = 32'(lock);
        FPEC_OFF_IRQ_STATUS: next_hrdata = 32'(irq_stat);
        FPEC_OFF_IRQ_MASK:   next_hrdata = 32'(irq_mask);
        FPEC_OFF_LINK_DATA:  next_hrdata = {24'h0, rx_word};
        FPEC_OFF_RAM_CHECK:  next_hrdata = 32'(in_ram(ram_probe));
        default:             next_hrdata = 32'h0;
      endcase
    end
    next_irq        = |(next_irq_stat & next_irq_mask);
    next_emu_active = next_emu_sel & next_emu_en;
    // RAM window decodes as RAM whether emulation is active or not
    next_ram_hit    = in_ram(next_ram_probe);
    // Link enabled only in boot mode; mode must hold stable meanwhile
    next_txen       = ~data_sync[1];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend             <= 1'b0;
      acc_off             <= 8'h00;
      hrdata              <= 32'h0;
      hreadyout           <= 1'b1;
      hresp               <= 1'b0;
      irq                 <= 1'b0;
      emulation_active    <= 1'b0;
      ram_window_hit      <= 1'b0;
      transfer_enable_out <= 1'b1;
    end else if (ce) begin
      if (hready) begin
        wr_pend <= take & hwrite;
        acc_off <= haddr[7:0];
      end
      hrdata              <= next_hrdata;
      irq                 <= next_irq;
      emulation_active    <= next_emu_active;
      ram_window_hit      <= next_ram_hit;
      transfer_enable_out <= next_txen;
    end
  end

  fpec_link #(
    .WIDTH(FPEC_LINK_BITS)
  ) u_link (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .active    (data_sync[1]),
    .sclk_rise (sclk_rise),
    .sclk_fall (sclk_fall),
    .data_in   (data_sync[0]),
    .tx_word   (tx_word),
    .data_out  (programmer_data_out),
    .rx_word   (rx_word),
    .rx_done   (rx_done)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_arm_pin_low: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !pin_high && !arm |=> !arm)
    else $error("arm set while protect pin low");
  a_arm_no_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !arm && !arm_zero_seen |=> !arm)
    else $error("arm set without preceding zero write");
  a_busy_needs_arm: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && state == FPEC_IDLE && !arm |=> state != FPEC_BUSY)
    else $error("sequencer started without arm");
  a_pin_blocks_pe: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && state == FPEC_IDLE && !pin_high |=> state != FPEC_BUSY)
    else $error("erase/write started with pin low");
  a_lock_blocks_pe: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && state == FPEC_IDLE && cmd_go && !lock[cmd_blk] |=> state != FPEC_BUSY)
    else $error("locked block started");
  a_reset_status: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && state != FPEC_BUSY && wr_now && acc_off == FPEC_OFF_CONTROL_FOUR
    && hwdata[FPEC_BIT_FLASH_RESET] && !cmd_go |=> stat_two == FPEC_STATUS_TWO_RESET)
    else $error("flash reset did not restore status two");
  a_idle_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && state == FPEC_BUSY |-> !stat_two[FPEC_BIT_PE_IDLE])
    else $error("idle flag set while busy");
  a_emu_needs_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    emu_en |-> emu_sel)
    else $error("substitution active outside emulation mode");
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    ce ##1 $past(ce) |-> irq == |($past(next_irq_stat) & $past(next_irq_mask)))
    else $error("irq does not follow masked status");
endmodule

/* verilog/fpec_pkg.sv */
// Package of offsets, fields, reset values and timing for the flash protect entry control
package fpec_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] FPEC_OFF_CONTROL_ONE  = 8'h00;
  localparam logic [7:0] FPEC_OFF_CONTROL_FOUR = 8'h04;
  localparam logic [7:0] FPEC_OFF_STATUS_ONE   = 8'h08;
  localparam logic [7:0] FPEC_OFF_STATUS_TWO   = 8'h0c;
  localparam logic [7:0] FPEC_OFF_MODE         = 8'h10;
  localparam logic [7:0] FPEC_OFF_BANK_MAP     = 8'h14;
  localparam logic [7:0] FPEC_OFF_LOCK         = 8'h18;
  localparam logic [7:0] FPEC_OFF_COMMAND      = 8'h1c;
  localparam logic [7:0] FPEC_OFF_IRQ_STATUS   = 8'h20;
  localparam logic [7:0] FPEC_OFF_IRQ_MASK     = 8'h24;
  localparam logic [7:0] FPEC_OFF_LINK_DATA    = 8'h28;
  localparam logic [7:0] FPEC_OFF_RAM_CHECK    = 8'h2c;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FPEC_BIT_ENTRY_ARM    = 0;
  localparam int FPEC_BIT_EMU_SELECT   = 1;
  localparam int FPEC_BIT_EMU_ENABLE   = 0;
  localparam int FPEC_BIT_FLASH_RESET  = 0;
  localparam int FPEC_BIT_SEQ_READY    = 7;
  localparam int FPEC_BIT_PE_IDLE      = 7;
  localparam int FPEC_BIT_ERR_PROTECT  = 4;
  localparam int FPEC_BIT_ERR_LOCK     = 5;
  localparam int FPEC_BIT_PIN_LEVEL    = 0;
  localparam int FPEC_BIT_BOOT_MODE    = 1;
  localparam int FPEC_BIT_CMD_ERASE    = 0;
  localparam int FPEC_BIT_CMD_WRITE    = 1;
  localparam int FPEC_CMD_BLOCK_LSB    = 8;
  // Interrupt status bits
  localparam int FPEC_IRQ_DONE         = 0;
  localparam int FPEC_IRQ_REJECT       = 1;
  localparam int FPEC_IRQ_LINK_BYTE    = 2;
  localparam int FPEC_IRQ_WIDTH        = 3;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  FPEC_STATUS_TWO_RESET = 8'h80;
  localparam logic [31:0] FPEC_LOCK_RESET       = 32'hffffffff;
  // ---------------------------------------------------------------
  // RAM window kept during emulation
  // ---------------------------------------------------------------
  localparam logic [31:0] FPEC_RAM_LOW  = 32'h00804000;
  localparam logic [31:0] FPEC_RAM_HIGH = 32'h00807fff;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int FPEC_CLK_MHZ      = 25;
  localparam int FPEC_PE_TIME_US   = 20;
  localparam int FPEC_PE_CYCLES    = FPEC_PE_TIME_US * FPEC_CLK_MHZ;
  localparam int FPEC_BLOCKS       = 32;
  localparam int FPEC_LINK_BITS    = 8;
endpackage

/* verilog/fpec_link.sv */
// Clock-synchronous serial link to the external programmer
`timescale 1ns/10ps
module fpec_link
  import fpec_pkg::*;
#(
  parameter int WIDTH = FPEC_LINK_BITS
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  input  wire logic             active,
  input  wire logic             sclk_rise,
  input  wire logic             sclk_fall,
  input  wire logic             data_in,
  input  wire logic [WIDTH-1:0] tx_word,
  output logic                  data_out,
  output logic [WIDTH-1:0]      rx_word,
  output logic                  rx_done
);
  logic [WIDTH-1:0] shift_in;
  logic [WIDTH-1:0] next_shift_in;
  logic [WIDTH-1:0] shift_out;
  logic [WIDTH-1:0] next_shift_out;
  logic [3:0]       count;
  logic [3:0]       next_count;
  logic [WIDTH-1:0] next_rx_word;
  logic             next_rx_done;
  logic             next_data_out;

  always_comb begin
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    next_count     = count;
    next_rx_word   = rx_word;
    next_rx_done   = 1'b0;
    next_data_out  = data_out;
    if (!active) begin
      next_count    = 4'h0;
      next_data_out = 1'b1;
    end else if (sclk_fall) begin
      // Data changes on the falling edge, LSB first
      if (count == 4'h0) begin
        next_data_out  = tx_word[0];
        next_shift_out = {1'b1, tx_word[WIDTH-1:1]};
      end else begin
        next_data_out  = shift_out[0];
        next_shift_out = {1'b1, shift_out[WIDTH-1:1]};
      end
    end else if (sclk_rise) begin
      next_shift_in = {data_in, shift_in[WIDTH-1:1]};
      if (count == 4'(WIDTH - 1)) begin
        next_count   = 4'h0;
        next_rx_word = {data_in, shift_in[WIDTH-1:1]};
        next_rx_done = 1'b1;
      end else begin
        next_count = count + 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_in  <= '0;
      shift_out <= '1;
      count     <= 4'h0;
      rx_word   <= '0;
      rx_done   <= 1'b0;
      data_out  <= 1'b1;
    end else if (ce) begin
      shift_in  <= next_shift_in;
      shift_out <= next_shift_out;
      count     <= next_count;
      rx_word   <= next_rx_word;
      rx_done   <= next_rx_done;
      data_out  <= next_data_out;
    end
  end
endmodule

/* verification/fpec_programmer_model.sv */
// Behavioural model of the external serial programmer on the link
`timescale 1ns/10ps
module fpec_programmer_model (
  output logic      link_clk,
  output logic      link_dout,
  input  wire logic link_din
);
  localparam int ID_FIRST = 32'h00000084;
  localparam int ID_LAST  = 32'h00000093;
  logic [7:0] last_rx;
  // Identifier area as the programmer reads it back from flash
  logic [7:0] id_area [ID_LAST-ID_FIRST+1];

  // Clock and data rest high between frames, as the pull-ups leave them
  initial begin
    link_clk = 1'b1;
    link_dout = 1'b1;
    last_rx = 8'h00;
    for (int i = 0; i <= ID_LAST - ID_FIRST; i++) begin
      id_area[i] = 8'hff;
    end
  end

  // Reprogramming refused unless the entry matches or the area is blank
  function automatic logic id_accept(input logic [127:0] entered);
    logic blank;
    logic same;
    blank = 1'b1;
    same  = 1'b1;
    for (int i = 0; i <= ID_LAST - ID_FIRST; i++) begin
      blank = blank & (id_area[i] == 8'hff);
      same  = same & (id_area[i] == entered[8*i +: 8]);
    end
    return blank | same;
  endfunction

  // One byte, bit 0 first: data goes on at the fall, both ends sample at the rise
  task automatic frame(input logic [7:0] tx);
    #7;
    for (int i = 0; i < 8; i++) begin
      link_clk = 1'b0;
      link_dout = tx[i];
      #160;
      link_clk = 1'b1;
      last_rx[i] = link_din;
      #160;
    end
    link_dout = 1'b1;
  endtask
endmodule

/* verification/tb_flash_protect_entry_control.sv */
// Self-checking bench for the flash protect entry control block
`timescale 1ns/10ps
module tb_flash_protect_entry_control
  import fpec_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        protect_pin;
  logic        boot_mode;
  logic        link_clk;
  logic        link_to_dut;
  logic        link_from_dut;
  logic        transfer_enable_out;
  logic        emulation_active;
  logic        ram_window_hit;
  logic        irq;
  logic [31:0] q;
  int          n_errors;
  int          samples_checked;
  logic [31:0] ram_addr [4] = '{32'h00804000, 32'h00807fff, 32'h00808000, 32'h00803fff};
  logic        ram_hit  [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  always #20 hclk = ~hclk;

  // Short erase/write time keeps the busy window readable yet brief
  fpec_top #(.BLOCKS(32), .PE_CYCLES(40)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .protect_pin(protect_pin), .boot_mode(boot_mode), .programmer_clock_in(link_clk),
    .programmer_data_in(link_to_dut), .programmer_data_out(link_from_dut),
    .transfer_enable_out(transfer_enable_out), .emulation_active(emulation_active),
    .ram_window_hit(ram_window_hit), .irq(irq)
  );

  fpec_programmer_model prog (
    .link_clk(link_clk), .link_dout(link_to_dut), .link_din(link_from_dut)
  );

  // ---------------------------------------------------------------
  // Bus tasks, entered just after a rising edge
  // ---------------------------------------------------------------
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, 32'h00000000);
    chk(q & m, e);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task arm();
    wr(FPEC_OFF_CONTROL_ONE, 32'h00000000);
    wr(FPEC_OFF_CONTROL_ONE, 32'h00000001);
  endtask

  task conclude();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole sequence needs well under 2000 bus clocks
  initial begin
    #200000;
    n_errors++;
    conclude();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    ce = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    protect_pin = 1'b1;
    boot_mode = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(3);
    rc(FPEC_OFF_STATUS_TWO, 32'h00000080, 32'hffffffff);
    rc(FPEC_OFF_STATUS_ONE, 32'h00000080, 32'h00000080);
    rc(FPEC_OFF_LOCK, 32'hffffffff, 32'hffffffff);
    rc(FPEC_OFF_MODE, 32'h00000001, 32'h00000001);
    rc(8'h3c, 32'h00000000, 32'hffffffff);
    chk({31'h0, hresp}, 32'h00000000);
    wr(FPEC_OFF_CONTROL_ONE, 32'h00000001);
    rc(FPEC_OFF_CONTROL_ONE, 32'h00000000, 32'h00000001);
    protect_pin <= 1'b0;
    cyc(3);
    rc(FPEC_OFF_MODE, 32'h00000000, 32'h00000001);
    arm();
    rc(FPEC_OFF_CONTROL_ONE, 32'h00000000, 32'h00000001);
    protect_pin <= 1'b1;
    cyc(3);
    wr(FPEC_OFF_COMMAND, 32'h00000001);
    rc(FPEC_OFF_IRQ_STATUS, 32'h00000002, 32'h00000002);
    arm();
    rc(FPEC_OFF_CONTROL_ONE, 32'h00000001, 32'h00000001);
    wr(FPEC_OFF_LOCK, 32'hfffffff7);
    wr(FPEC_OFF_COMMAND, 32'h00000302);
    rc(FPEC_OFF_STATUS_TWO, 32'h000000a0, 32'h000000a0);
    rc(FPEC_OFF_STATUS_ONE, 32'h00000080, 32'h00000080);
    wr(FPEC_OFF_CONTROL_FOUR, 32'h00000001);
    cyc(2);
    rc(FPEC_OFF_STATUS_TWO, 32'h00000080, 32'h000000ff);
    protect_pin <= 1'b0;
    cyc(3);
    wr(FPEC_OFF_COMMAND, 32'h00000001);
    rc(FPEC_OFF_STATUS_TWO, 32'h00000090, 32'h00000090);
    wr(FPEC_OFF_CONTROL_FOUR, 32'h00000001);
    protect_pin <= 1'b1;
    cyc(3);
    arm();
    wr(FPEC_OFF_IRQ_STATUS, 32'h00000007);
    wr(FPEC_OFF_IRQ_MASK, 32'h00000001);
    wr(FPEC_OFF_COMMAND, 32'h00000001);
    rc(FPEC_OFF_STATUS_ONE, 32'h00000000, 32'h00000080);
    rc(FPEC_OFF_STATUS_TWO, 32'h00000000, 32'h00000080);
    cyc(60);
    rc(FPEC_OFF_STATUS_ONE, 32'h00000080, 32'h00000080);
    rc(FPEC_OFF_STATUS_TWO, 32'h00000080, 32'h00000080);
    chk({31'h0, irq}, 32'h00000001);
    wr(FPEC_OFF_IRQ_MASK, 32'h00000000);
    cyc(2);
    chk({31'h0, irq}, 32'h00000000);
    wr(FPEC_OFF_IRQ_MASK, 32'h00000001);
    wr(FPEC_OFF_IRQ_STATUS, 32'h00000001);
    cyc(2);
    chk({31'h0, irq}, 32'h00000000);
    rc(FPEC_OFF_IRQ_STATUS, 32'h00000000, 32'h00000001);
    wr(FPEC_OFF_CONTROL_ONE, 32'h00000000);
    wr(FPEC_OFF_BANK_MAP, 32'h00000001);
    cyc(2);
    chk({31'h0, emulation_active}, 32'h00000000);
    wr(FPEC_OFF_CONTROL_ONE, 32'h00000002);
    wr(FPEC_OFF_BANK_MAP, 32'h00000001);
    cyc(2);
    chk({31'h0, emulation_active}, 32'h00000001);
    for (int i = 0; i < 4; i++) begin
      wr(FPEC_OFF_RAM_CHECK, ram_addr[i]);
      cyc(2);
      chk({31'h0, ram_window_hit}, {31'h0, ram_hit[i]});
    end
    // A write made while the clock enable is low must not land
    ce <= 1'b0;
    wr(FPEC_OFF_RAM_CHECK, ram_addr[0]);
    ce <= 1'b1;
    cyc(2);
    chk({31'h0, ram_window_hit}, 32'h00000000);
    wr(FPEC_OFF_CONTROL_ONE, 32'h00000000);
    cyc(2);
    chk({31'h0, emulation_active}, 32'h00000000);
    rc(FPEC_OFF_BANK_MAP, 32'h00000000, 32'h00000001);
    boot_mode <= 1'b1;
    cyc(4);
    chk({31'h0, transfer_enable_out}, 32'h00000000);
    rc(FPEC_OFF_MODE, 32'h00000002, 32'h00000002);
    wr(FPEC_OFF_LINK_DATA, 32'h000000a5);
    prog.frame(8'h3c);
    cyc(8);
    chk({24'h0, prog.last_rx}, 32'h000000a5);
    rc(FPEC_OFF_LINK_DATA, 32'h0000003c, 32'h000000ff);
    rc(FPEC_OFF_IRQ_STATUS, 32'h00000004, 32'h00000004);
    chk({31'h0, prog.id_accept(128'h0)}, 32'h00000001);
    prog.id_area[0] = 8'h5a;
    chk({31'h0, prog.id_accept(128'h0)}, 32'h00000000);
    chk({31'h0, prog.id_accept({{15{8'hff}}, 8'h5a})}, 32'h00000001);
    conclude();
  end
endmodule
